// *** rtl/gpio_cfg.svh ***
// Offsets, field positions, reset values and sizes of the three-pin port.
// Assumes inclusion by bare name from the package and the top module.
`ifndef GPIO_CFG_SVH
`define GPIO_CFG_SVH

`define PIN_COUNT      3
`define ADDR_WIDTH     12
`define CFG_REG_OFS    12'h1e0
`define DATA_REG_OFS   12'h1e4
`define DRV_TYPE_LSB   0
`define EVT_OE_LSB     8
`define EVT_POL_LSB    16
`define OUT_VAL_LSB    0
`define DIR_LSB        16
`define PIN_FIELD_RST  3'h0
`define WORD_RST       32'h0000_0000

`endif

// *** rtl/gpio_pkg.sv ***
// Types shared by the three-pin port, the outside pin model and the bench.
// Assumes gpio_cfg.svh is on the include path.
`include "gpio_cfg.svh"

package gpio_pkg;

  typedef logic [`PIN_COUNT-1:0]  pin_vec_t;
  typedef logic [31:0]            word_t;
  typedef logic [`ADDR_WIDTH-1:0] addr_t;
  typedef logic [3:0]             byte_sel_t;

  typedef enum logic [1:0] {
    REG_NONE = 2'b00,
    REG_CFG  = 2'b01,
    REG_DATA = 2'b10
  } reg_sel_e;

endpackage

// *** rtl/pin_cell.sv ***
// One pin: input synchroniser and registered driver.
// Assumes the pin level is asynchronous to clk_i and that drive requests
// come from logic on clk_i.
`timescale 1ns/100ps

module pin_cell (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic pin_i,
  input  wire logic push_pull_i,
  input  wire logic drive_en_i,
  input  wire logic level_i,
  output logic      pin_o,
  output logic      pin_oe_o,
  output logic      pin_sync_o
);

  logic sync1_ff;
  logic sync2_ff;
  logic out_ff;
  logic oe_ff;
  logic nxt_sync1;
  logic nxt_sync2;
  logic nxt_out;
  logic nxt_oe;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_sync1 = pin_i;
    nxt_sync2 = sync1_ff;                      // [R11]
    // Open drain never drives high: a high level releases the pin
    nxt_out   = push_pull_i ? level_i : 1'b0;  // [R1] [R2]
    nxt_oe    = drive_en_i & (push_pull_i | ~level_i); // [R2] [R3]
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      out_ff   <= 1'b0;
      oe_ff    <= 1'b0;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      out_ff   <= nxt_out;
      oe_ff    <= nxt_oe;
    end
  end

  assign pin_o      = out_ff;
  assign pin_oe_o   = oe_ff;
  assign pin_sync_o = sync2_ff;

endmodule

// *** rtl/three_pin_gpio_data_direction.sv ***
// Three general pins behind two Wishbone registers, with clock-event drive.
// Assumes a classic Wishbone master on clk_i, clock events from logic on
// clk_i, and pins whose wire level is resolved outside from pin_oe_o.
//
// Functional notes
// (R1) Driver type field resets to zero; zero open drain, one push/pull.
// (R2) Open drain pulls low on data zero, releases the pin on data one.
// (R3) Open drain events: polarity zero drives low on event, one when idle.
// (R4) Direction field resets to zero; zero input, one output.
// (R5) An output pin carries the last written output value bit; pins with event enable set carry the event level instead.
// (R6) Data read returns the synchronised pin level for input pins.
// (R7) Data read returns the last written bit for output pins.
// (R8) Direction bit or event output enable makes a pin an output.
// (R9) Event enable forces output; driver type still applies.
// (R10) Polarity bit gives the active level of the event on the pin.
// (R11) Pin levels pass two flip-flops before being read back.
`timescale 1ns/100ps
`include "gpio_cfg.svh"

module three_pin_gpio_data_direction (
  input  wire logic                clk_i,
  input  wire logic                reset_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire gpio_pkg::addr_t     wb_adr_i,
  input  wire gpio_pkg::byte_sel_t wb_sel_i,
  input  wire gpio_pkg::word_t     wb_dat_i,
  output gpio_pkg::word_t          wb_dat_o,
  output logic                     wb_ack_o,
  input  wire gpio_pkg::pin_vec_t  pin_i,
  output gpio_pkg::pin_vec_t       pin_o,
  output gpio_pkg::pin_vec_t       pin_oe_o,
  input  wire gpio_pkg::pin_vec_t  event_i,
  output gpio_pkg::pin_vec_t       event_oe_o,
  output gpio_pkg::pin_vec_t       event_pol_o
);

  import gpio_pkg::*;

  logic     ack_ff;
  word_t    rdat_ff;
  pin_vec_t drv_type_ff;
  pin_vec_t evt_oe_ff;
  pin_vec_t evt_pol_ff;
  pin_vec_t out_val_ff;
  pin_vec_t dir_ff;

  logic     nxt_ack;
  word_t    nxt_rdat;
  pin_vec_t nxt_drv_type;
  pin_vec_t nxt_evt_oe;
  pin_vec_t nxt_evt_pol;
  pin_vec_t nxt_out_val;
  pin_vec_t nxt_dir;

  reg_sel_e reg_sel;
  logic     req;
  logic     wr_go;
  pin_vec_t eff_out;
  pin_vec_t level;
  pin_vec_t pin_sync;
  pin_vec_t read_val;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode; word aligned, low two address bits ignored
  always_comb begin
    reg_sel = REG_NONE;
    if (wb_adr_i[`ADDR_WIDTH-1:2] == 10'(`CFG_REG_OFS >> 2)) begin
      reg_sel = REG_CFG;
    end else if (wb_adr_i[`ADDR_WIDTH-1:2] == 10'(`DATA_REG_OFS >> 2)) begin
      reg_sel = REG_DATA;
    end
  end

  // Ack blocks a second take of the same request
  assign req = wb_cyc_i & wb_stb_i & ~ack_ff;

  // Writes land at the edge that shows ack, where the master completes;
  // a master that gives up before ack leaves the registers untouched
  assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Pin behaviour
  assign eff_out = dir_ff | evt_oe_ff;                     // [R8] [R9]

  // Event pins: active level is the polarity bit, idle its inverse
  assign level = (evt_oe_ff & ~(event_i ^ evt_pol_ff))     // [R3] [R10]
               | (~evt_oe_ff & out_val_ff);                // [R5]

  // Inputs show the pin, outputs the written value
  assign read_val = (eff_out & out_val_ff)                 // [R7]
                  | (~eff_out & pin_sync);                 // [R6]

  for (genvar i = 0; i < `PIN_COUNT; i++) begin : g_pin
    pin_cell u_pin (
      .clk_i       (clk_i),
      .reset_i     (reset_i),
      .pin_i       (pin_i[i]),
      .push_pull_i (drv_type_ff[i]),
      .drive_en_i  (eff_out[i]),
      .level_i     (level[i]),
      .pin_o       (pin_o[i]),
      .pin_oe_o    (pin_oe_o[i]),
      .pin_sync_o  (pin_sync[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  always_comb begin
    nxt_ack      = req;
    nxt_rdat     = `WORD_RST;
    nxt_drv_type = drv_type_ff;
    nxt_evt_oe   = evt_oe_ff;
    nxt_evt_pol  = evt_pol_ff;
    nxt_out_val  = out_val_ff;
    nxt_dir      = dir_ff;
    if (req || wr_go) begin
      unique case (reg_sel)
        REG_CFG: begin
          if (wr_go) begin
            if (wb_sel_i[`DRV_TYPE_LSB/8]) begin
              nxt_drv_type = wb_dat_i[`DRV_TYPE_LSB +: `PIN_COUNT];
            end
            if (wb_sel_i[`EVT_OE_LSB/8]) begin
              nxt_evt_oe = wb_dat_i[`EVT_OE_LSB +: `PIN_COUNT];
            end
            if (wb_sel_i[`EVT_POL_LSB/8]) begin
              nxt_evt_pol = wb_dat_i[`EVT_POL_LSB +: `PIN_COUNT];
            end
          end else if (!wb_we_i) begin
            nxt_rdat[`DRV_TYPE_LSB +: `PIN_COUNT] = drv_type_ff;
            nxt_rdat[`EVT_OE_LSB +: `PIN_COUNT]   = evt_oe_ff;
            nxt_rdat[`EVT_POL_LSB +: `PIN_COUNT]  = evt_pol_ff;
          end
        end
        REG_DATA: begin
          if (wr_go) begin
            if (wb_sel_i[`OUT_VAL_LSB/8]) begin
              nxt_out_val = wb_dat_i[`OUT_VAL_LSB +: `PIN_COUNT]; // [R5]
            end
            if (wb_sel_i[`DIR_LSB/8]) begin
              nxt_dir = wb_dat_i[`DIR_LSB +: `PIN_COUNT];
            end
          end else if (!wb_we_i) begin
            nxt_rdat[`OUT_VAL_LSB +: `PIN_COUNT] = read_val;     // [R6] [R7]
            nxt_rdat[`DIR_LSB +: `PIN_COUNT]     = dir_ff;
          end
        end
        // Unmapped: acknowledged, reads zero, writes dropped
        default: begin
          nxt_rdat = `WORD_RST;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ack_ff      <= 1'b0;
      rdat_ff     <= `WORD_RST;
      drv_type_ff <= `PIN_FIELD_RST;                       // [R1]
      evt_oe_ff   <= `PIN_FIELD_RST;
      evt_pol_ff  <= `PIN_FIELD_RST;
      out_val_ff  <= `PIN_FIELD_RST;
      dir_ff      <= `PIN_FIELD_RST;                       // [R4]
    end else begin
      ack_ff      <= nxt_ack;
      rdat_ff     <= nxt_rdat;
      drv_type_ff <= nxt_drv_type;
      evt_oe_ff   <= nxt_evt_oe;
      evt_pol_ff  <= nxt_evt_pol;
      out_val_ff  <= nxt_out_val;
      dir_ff      <= nxt_dir;
    end
  end

  assign wb_ack_o    = ack_ff;
  assign wb_dat_o    = rdat_ff;
  assign event_oe_o  = evt_oe_ff;
  assign event_pol_o = evt_pol_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  AST_CFG_RESET: assert property ( // [R1]
    $past(reset_i) |-> (drv_type_ff == `PIN_FIELD_RST)
                    && (evt_oe_ff == `PIN_FIELD_RST)
  ) else $error("driver type not cleared by reset");

  AST_OD_DATA: assert property ( // [R2]
    !$past(reset_i) |->
      (($past(dir_ff) & ~$past(evt_oe_ff) & ~$past(drv_type_ff))
       & ((pin_oe_o ^ ~$past(out_val_ff)) | pin_o)) == 3'h0
  ) else $error("open drain pin not driven from data");

  AST_OD_EVENT: assert property ( // [R3]
    !$past(reset_i) |->
      (($past(evt_oe_ff) & ~$past(drv_type_ff))
       & ((pin_oe_o ^ ($past(event_i) ^ $past(evt_pol_ff))) | pin_o))
      == 3'h0
  ) else $error("open drain event drive wrong for polarity");

  AST_DIR_RESET: assert property ( // [R4]
    $past(reset_i) |-> dir_ff == `PIN_FIELD_RST && pin_oe_o == 3'h0
  ) else $error("direction not cleared by reset");

  AST_PP_DATA: assert property ( // [R5]
    !$past(reset_i) |->
      (($past(dir_ff) & ~$past(evt_oe_ff) & $past(drv_type_ff))
       & ((pin_o ^ $past(out_val_ff)) | ~pin_oe_o)) == 3'h0
  ) else $error("push pull output does not follow data");

  AST_READ_INPUT: assert property ( // [R6]
    wb_ack_o && !$past(wb_we_i) && $past(reg_sel) == REG_DATA |->
      ((wb_dat_o[2:0] ^ $past(pin_sync)) & ~$past(eff_out)) == 3'h0
  ) else $error("input pin read does not show pin level");

  AST_READ_OUTPUT: assert property ( // [R7]
    wb_ack_o && !$past(wb_we_i) && $past(reg_sel) == REG_DATA |->
      ((wb_dat_o[2:0] ^ $past(out_val_ff)) & $past(eff_out)) == 3'h0
  ) else $error("output pin read does not show written value");

  AST_EFF_OUT: assert property ( // [R8]
    !$past(reset_i) |->
      ((~$past(dir_ff) & ~$past(evt_oe_ff)) & pin_oe_o) == 3'h0
  ) else $error("pin driven while configured as input");

  AST_EVT_FORCE: assert property ( // [R9]
    !$past(reset_i) |->
      ($past(evt_oe_ff) & $past(drv_type_ff) & ~pin_oe_o) == 3'h0
  ) else $error("event enable did not force output");

  AST_PP_EVENT: assert property ( // [R10]
    !$past(reset_i) |->
      (($past(evt_oe_ff) & $past(drv_type_ff))
       & (pin_o ^ ~($past(event_i) ^ $past(evt_pol_ff)))) == 3'h0
  ) else $error("push pull event level ignores polarity");

  AST_SYNC_DELAY: assert property ( // [R11]
    !$past(reset_i) && !$past(reset_i, 2) |-> pin_sync == $past(pin_i, 2)
  ) else $error("pin level not two cycles behind");

  AST_ACK_PULSE: assert property (
    wb_ack_o |=> !wb_ack_o
  ) else $error("ack held longer than one cycle");

  AST_ACK_TIME: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o
  ) else $error("request not acknowledged in one cycle");

  // No register field may change at the take edge of a write
  AST_WRITE_LATE: assert property (
    req && wb_we_i |=> $stable(drv_type_ff) && $stable(evt_oe_ff)
                       && $stable(evt_pol_ff) && $stable(out_val_ff)
                       && $stable(dir_ff)
  ) else $error("register written before the ack edge");

  AST_DRV_WRITE: assert property ( // [R1]
    wr_go && reg_sel == REG_CFG && wb_sel_i[`DRV_TYPE_LSB/8] |=>
      drv_type_ff == $past(wb_dat_i[`DRV_TYPE_LSB +: `PIN_COUNT])
  ) else $error("driver type write lost");

  AST_OE_WRITE: assert property ( // [R9]
    wr_go && reg_sel == REG_CFG && wb_sel_i[`EVT_OE_LSB/8] |=>
      evt_oe_ff == $past(wb_dat_i[`EVT_OE_LSB +: `PIN_COUNT])
  ) else $error("event output enable write lost");

  AST_POL_WRITE: assert property ( // [R10]
    wr_go && reg_sel == REG_CFG && wb_sel_i[`EVT_POL_LSB/8] |=>
      evt_pol_ff == $past(wb_dat_i[`EVT_POL_LSB +: `PIN_COUNT])
  ) else $error("polarity write lost");

  AST_DIR_WRITE: assert property ( // [R4]
    wr_go && reg_sel == REG_DATA && wb_sel_i[`DIR_LSB/8] |=>
      dir_ff == $past(wb_dat_i[`DIR_LSB +: `PIN_COUNT])
  ) else $error("direction write lost");

  AST_OUT_WRITE: assert property ( // [R5]
    wr_go && reg_sel == REG_DATA && wb_sel_i[`OUT_VAL_LSB/8] |=>
      out_val_ff == $past(wb_dat_i[`OUT_VAL_LSB +: `PIN_COUNT])
  ) else $error("output value write lost");

  AST_UNMAPPED_READ: assert property (
    wb_ack_o && $past(reg_sel) == REG_NONE |-> wb_dat_o == `WORD_RST
  ) else $error("unmapped address read not zero");

  AST_DAT_IDLE: assert property (
    !wb_ack_o |-> wb_dat_o == `WORD_RST
  ) else $error("read data not zero outside ack");

  COV_OD_EVENT: cover property (
    (evt_oe_ff[0] && !drv_type_ff[0] && !evt_pol_ff[0] && event_i[0])
    ##1 pin_oe_o[0]
  );

  COV_READ_INPUT: cover property (
    wb_ack_o && !$past(wb_we_i) && $past(reg_sel) == REG_DATA
    && $past(eff_out) == 3'h0
  );

  COV_WRITE_DIR: cover property (
    wr_go && reg_sel == REG_DATA ##1 dir_ff != 3'h0
  );

  COV_UNMAPPED: cover property (
    req && reg_sel == REG_NONE ##1 wb_ack_o
  );

endmodule

// *** dv/pin_ext_model.sv ***
// Circuitry outside the three pins: optional drivers and a pull-up.
// Assumes the device drive value and enable come from the port under test.
`timescale 1ns/100ps
`include "gpio_cfg.svh"

module pin_ext_model (
  input  wire gpio_pkg::pin_vec_t drive_val_i,
  input  wire gpio_pkg::pin_vec_t drive_en_i,
  input  wire gpio_pkg::pin_vec_t ext_en_i,
  input  wire gpio_pkg::pin_vec_t ext_lvl_i,
  output gpio_pkg::pin_vec_t      wire_o
);
  import gpio_pkg::*;

  // Device wins over outside drivers; a released pin floats up
  always_comb begin
    for (int i = 0; i < `PIN_COUNT; i++) begin
      wire_o[i] = drive_en_i[i] ? drive_val_i[i] :
                  ext_en_i[i] ? ext_lvl_i[i] : 1'b1;
    end
  end
endmodule

// *** dv/tb_three_pin_gpio_data_direction.sv ***
// Self-checking bench for the three-pin port.
// Assumes the port acks one cycle after the take edge.
`timescale 1ns/100ps
`include "gpio_cfg.svh"

module tb_three_pin_gpio_data_direction;
  import gpio_pkg::*;

  logic      clk_i = 1'b0;
  logic      reset_i = 1'b1;
  logic      wb_cyc_i = 1'b0;
  logic      wb_stb_i = 1'b0;
  logic      wb_we_i = 1'b0;
  addr_t     wb_adr_i = '0;
  byte_sel_t wb_sel_i = '0;
  word_t     wb_dat_i = '0;
  word_t     wb_dat_o;
  logic      wb_ack_o;
  pin_vec_t  pin_i;
  pin_vec_t  pin_o;
  pin_vec_t  pin_oe_o;
  pin_vec_t  event_i = '0;
  pin_vec_t  event_oe_o;
  pin_vec_t  event_pol_o;
  pin_vec_t  ext_en = '0;
  pin_vec_t  ext_lvl = '0;
  int        fails = 0;
  int        cmp_count = 0;
  word_t     exp_q[$];
  word_t     exp_w;

  always #2 clk_i = ~clk_i;

  three_pin_gpio_data_direction three_pin_gpio_data_direction_inst (
    .clk_i(clk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .event_i(event_i), .event_oe_o(event_oe_o),
    .event_pol_o(event_pol_o));

  pin_ext_model pin_ext_model_inst (
    .drive_val_i(pin_o), .drive_en_i(pin_oe_o), .ext_en_i(ext_en),
    .ext_lvl_i(ext_lvl), .wire_o(pin_i));

  //////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input word_t e, input word_t s);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Held until ack is seen at a rising edge, then released
  task automatic wb(input logic we, input addr_t a, input word_t d,
                    input byte_sel_t s);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    if (wb_ack_o !== 1'b1) begin
      fails++;
      complete_run();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input addr_t a, input word_t e);
    exp_q.push_back(e);
    wb(1'b0, a, '0, 4'hf);
  endtask

  // Read data is judged only in the cycle that carries ack
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      exp_w = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
      chk("read_data", exp_w, wb_dat_o);
    end
  end

  //////////////////////////////////////////////////////////////////
  initial begin
    word_t     w;
    byte_sel_t s;
    pin_vec_t  t, d, o, p, v, e, xe, xl, eff, lvl, wl, rv;
    void'($urandom(72563));
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    ext_en  <= 3'h5;
    ext_lvl <= 3'h4;
    repeat (3) @(posedge clk_i);
    chk("oe_reset", '0, 32'(pin_oe_o));
    rd(`CFG_REG_OFS, '0);
    rd(`DATA_REG_OFS, 32'h0000_0006);
    $display("test reset done");
    d = '0;
    v = '0;
    for (int i = 0; i < 40; i++) begin
      w = $urandom;
      t = w[2:0];
      o = w[10:8];
      p = w[18:16];
      wb(1'b1, `CFG_REG_OFS, w, 4'hf);
      w = $urandom;
      s = 4'($urandom);
      if (s[0]) v = w[2:0];
      if (s[2]) d = w[18:16];
      wb(1'b1, `DATA_REG_OFS, w, s);
      e  = 3'($urandom);
      xe = 3'($urandom);
      xl = 3'($urandom);
      event_i <= e;
      ext_en  <= xe;
      ext_lvl <= xl;
      repeat (3) @(posedge clk_i);
      eff = d | o;
      lvl = (o & ~(e ^ p)) | (~o & v);
      wl  = (xe & xl) | ~xe;
      chk("pin_oe", 32'(eff & (t | ~lvl)), 32'(pin_oe_o));
      // An undriven push/pull pin still shows its level on pin_o
      chk("pin_out", 32'(t & lvl), 32'(pin_o));
      chk("evt_cfg", 32'({o, p}), 32'({event_oe_o, event_pol_o}));
      rd(`CFG_REG_OFS, {13'h0, p, 5'h0, o, 5'h0, t});
      rv  = (eff & v) | (~eff & wl);
      rd(`DATA_REG_OFS, {13'h0, d, 13'h0, rv});
    end
    $display("test random pins done");
    wb(1'b1, 12'h1e8, 32'hffff_ffff, 4'hf);
    rd(12'h1e8, '0);
    rd(`CFG_REG_OFS, {13'h0, p, 5'h0, o, 5'h0, t});
    $display("test unmapped done");
    // Reset again in mid run; outside drivers stay as the last random setup left them
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("oe_rerun", '0, 32'(pin_oe_o));
    rd(`CFG_REG_OFS, '0);
    rd(`DATA_REG_OFS, {29'h0, wl});
    $display("test mid reset done");
    complete_run();
  end

  initial begin
    #40000;
    fails++;
    complete_run();
  end
endmodule
